/* File: rtl/pciarb_cfg.svh */
// Constants for the arbitration and error pin block
//
// Functional notes
// - Arbiter-select strap is caught at reset; it picks internal or external arbiter.
// - Internal arbiter mode: request lines 3 and 2 are active-low request inputs.
// - External arbiter mode: request lines 3 and 2 stay inputs, ignored, board pulls up.
// - Request line 1: request input internally, open-drain interrupt output externally.
// - Request line 0 is an active-low bus request in both arbiter modes.
// - Internal arbiter mode: all four active-low grant lines are driven outputs.
// - External mode: grant 0 is our grant input; grants 3..1 inputs, board pulls up.
// - Host strap: host mode samples system error, satellite mode drives it open-drain.
// - System error reports address parity, special-cycle data parity or fatal errors.
// - Data parity error line reports only data parity errors on configuration writes that this device claims.
// - The addressed target asserts device select to claim the access.
// - Initialization device select qualifies configuration accesses to this device.
`ifndef PCIARB_CFG_SVH
`define PCIARB_CFG_SVH

// ----------------------------------------------------------------------------
// Strap levels
// ----------------------------------------------------------------------------
`define PCIARB_STRAP_INTERNAL 1'b1
`define PCIARB_STRAP_HOST 1'b1

// ----------------------------------------------------------------------------
// Bus commands
// ----------------------------------------------------------------------------
`define PCIARB_CMD_SPECIAL 4'h1
`define PCIARB_CMD_CFG_RD 4'hA
`define PCIARB_CMD_CFG_WR 4'hB

// ----------------------------------------------------------------------------
// Arbiter layout and reset values
// ----------------------------------------------------------------------------
`define PCIARB_NUM_SLOTS 5
`define PCIARB_OWN_SLOT 3'h4
`define PCIARB_RST_LAST 3'h4
`define PCIARB_RST_GNT_N 4'hF

`endif

/* File: rtl/pciarb_pkg.sv */
// Types for the arbitration and error pin block
package pciarb_pkg;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_GRANT,
    ARB_TURN
  } pciarb_arb_state_t;

  typedef logic [2:0] pciarb_slot_t;

endpackage : pciarb_pkg

/* File: rtl/pciarb_evt_if.sv */
// Event carrier between clock domains
`timescale 1ns/1ps
interface pciarb_evt_if;
  logic src_pulse;
  logic dst_pulse;

  modport xfer (
    input src_pulse,
    output dst_pulse
  );

  modport user (
    output src_pulse,
    input dst_pulse
  );
endinterface : pciarb_evt_if

/* File: rtl/pciarb_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module pciarb_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : pciarb_sync

/* File: rtl/pciarb_evt_xfer.sv */
// Toggle crossing for single-cycle events
`timescale 1ns/1ps
module pciarb_evt_xfer (
  input wire logic src_clk_i,
  input wire logic src_rst_i,
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  pciarb_evt_if.xfer evt
);

  logic tgl_q;
  logic meta_q;
  logic sync_q;
  logic seen_q;
  logic pulse_q;

  // ----------------------------------------------------------------------------
  // Source side toggle
  // ----------------------------------------------------------------------------
  always_ff @(posedge src_clk_i)
  begin
    if (src_rst_i)
      tgl_q <= 1'b0;
    else if (evt.src_pulse)
      tgl_q <= ~tgl_q;
  end

  // ----------------------------------------------------------------------------
  // Destination side edge
  // ----------------------------------------------------------------------------
  always_ff @(posedge dst_clk_i)
  begin
    if (dst_rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      seen_q <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      meta_q <= tgl_q;
      sync_q <= meta_q;
      seen_q <= sync_q;
      pulse_q <= sync_q ^ seen_q;
    end
  end

  assign evt.dst_pulse = pulse_q;

endmodule : pciarb_evt_xfer

/* File: rtl/pciarb_top.sv */
// Arbitration, strap and error pin logic at the bus
`timescale 1ns/1ps
`include "pciarb_cfg.svh"
module pciarb_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic pci_clk_i,
  input wire logic arb_strap_i,
  input wire logic host_strap_i,
  input wire logic own_req_i,
  input wire logic ext_int_req_i,
  input wire logic fatal_err_i,
  input wire logic [3:0] req_n_i,
  output logic req0_n_o,
  output logic req0_n_oe_o,
  output logic ext_int_o,
  output logic ext_int_oe_o,
  input wire logic [3:0] gnt_n_i,
  output logic [3:0] gnt_n_o,
  output logic [3:0] gnt_n_oe_o,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic trdy_n_i,
  input wire logic idsel_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_n_i,
  input wire logic par_i,
  input wire logic devsel_n_i,
  output logic devsel_n_o,
  output logic devsel_n_oe_o,
  input wire logic perr_n_i,
  output logic perr_n_o,
  output logic perr_n_oe_o,
  input wire logic serr_n_i,
  output logic serr_n_o,
  output logic serr_n_oe_o,
  output logic arb_internal_o,
  output logic host_mode_o,
  output logic own_gnt_o,
  output logic cfg_claim_o,
  output logic serr_seen_o
);

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  function automatic pciarb_pkg::pciarb_slot_t pick_next(
    input logic [`PCIARB_NUM_SLOTS-1:0] req,
    input pciarb_pkg::pciarb_slot_t last
  );
    pciarb_pkg::pciarb_slot_t sel;
    int idx;
    sel = last;
    for (int i = `PCIARB_NUM_SLOTS; i >= 1; i--)
    begin
      idx = (int'(last) + i) % `PCIARB_NUM_SLOTS;
      if (req[idx])
        sel = pciarb_pkg::pciarb_slot_t'(idx);
    end
    return sel;
  endfunction : pick_next

  function automatic logic parity_bad(
    input logic [31:0] ad,
    input logic [3:0] cbe_n,
    input logic par
  );
    return ^{ad, cbe_n, par};
  endfunction : parity_bad

  // ----------------------------------------------------------------------------
  // Reset, straps and core levels into the bus domain
  // ----------------------------------------------------------------------------
  logic pci_rst;
  logic [1:0] strap_s;
  logic [2:0] core_s;
  logic arb_int_q;
  logic host_q;

  pciarb_sync #(.W(1)) u_rst_sync (
    .clk_i(pci_clk_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(pci_rst)
  );

  pciarb_sync #(.W(2)) u_strap_sync (
    .clk_i(pci_clk_i),
    .rst_i(1'b0),
    .d_i({host_strap_i, arb_strap_i}),
    .q_o(strap_s)
  );

  pciarb_sync #(.W(3)) u_core_sync (
    .clk_i(pci_clk_i),
    .rst_i(pci_rst),
    .d_i({fatal_err_i, ext_int_req_i, own_req_i}),
    .q_o(core_s)
  );

  // Straps follow the pins during reset and freeze at its release
  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
    begin
      arb_int_q <= (strap_s[0] == `PCIARB_STRAP_INTERNAL);
      host_q <= (strap_s[1] == `PCIARB_STRAP_HOST);
    end
  end

  // ----------------------------------------------------------------------------
  // Internal arbiter
  // ----------------------------------------------------------------------------
  pciarb_pkg::pciarb_arb_state_t arb_state_q;
  pciarb_pkg::pciarb_slot_t owner_q;
  pciarb_pkg::pciarb_slot_t last_q;
  logic [`PCIARB_NUM_SLOTS-1:0] req_vec;
  logic [`PCIARB_NUM_SLOTS-1:0] gnt_vec;

  // Pin requests 3..0 plus the device's own master
  assign req_vec = arb_int_q ? {core_s[0], ~req_n_i} : '0;

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst || !arb_int_q)
    begin
      arb_state_q <= pciarb_pkg::ARB_IDLE;
      owner_q <= `PCIARB_RST_LAST;
      last_q <= `PCIARB_RST_LAST;
    end
    else
    begin
      unique case (arb_state_q)
        pciarb_pkg::ARB_IDLE:
        begin
          if (|req_vec)
          begin
            owner_q <= pick_next(req_vec, last_q);
            arb_state_q <= pciarb_pkg::ARB_GRANT;
          end
        end
        pciarb_pkg::ARB_GRANT:
        begin
          if (!req_vec[owner_q])
          begin
            last_q <= owner_q;
            arb_state_q <= pciarb_pkg::ARB_TURN;
          end
        end
        pciarb_pkg::ARB_TURN:
          arb_state_q <= pciarb_pkg::ARB_IDLE;
      endcase
    end
  end

  // One-hot grant, only while the owner still requests
  always_comb
  begin
    gnt_vec = '0;
    if (arb_state_q == pciarb_pkg::ARB_GRANT && req_vec[owner_q])
      gnt_vec[owner_q] = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // Request, grant and interrupt pins
  // ----------------------------------------------------------------------------
  logic [3:0] gnt_n_q;
  logic own_gnt_p_q;
  logic req0_n_q;
  logic ext_int_oe_q;

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      gnt_n_q <= `PCIARB_RST_GNT_N;
    else
      gnt_n_q <= ~gnt_vec[3:0];
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      own_gnt_p_q <= 1'b0;
    else if (arb_int_q)
      own_gnt_p_q <= gnt_vec[`PCIARB_OWN_SLOT];
    else
      own_gnt_p_q <= ~gnt_n_i[0];
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
    begin
      req0_n_q <= 1'b1;
      ext_int_oe_q <= 1'b0;
    end
    else
    begin
      req0_n_q <= ~(core_s[0] && !arb_int_q);
      ext_int_oe_q <= core_s[1] && !arb_int_q;
    end
  end

  assign gnt_n_o = gnt_n_q;
  assign gnt_n_oe_o = {4{arb_int_q && !pci_rst}};
  assign req0_n_o = req0_n_q;
  assign req0_n_oe_o = !arb_int_q && !pci_rst;
  assign ext_int_o = 1'b0;
  assign ext_int_oe_o = ext_int_oe_q;

  // ----------------------------------------------------------------------------
  // Transaction tracking and device select
  // ----------------------------------------------------------------------------
  logic frame_n_q;
  logic addr_ph;
  logic [3:0] cmd_q;
  logic claim_q;
  logic claim_evt;

  assign addr_ph = frame_n_q && !frame_n_i;
  assign claim_evt = addr_ph && idsel_i
    && (cbe_n_i == `PCIARB_CMD_CFG_RD || cbe_n_i == `PCIARB_CMD_CFG_WR);

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
    begin
      frame_n_q <= 1'b1;
      cmd_q <= 4'h0;
    end
    else
    begin
      frame_n_q <= frame_n_i;
      if (addr_ph)
        cmd_q <= cbe_n_i;
    end
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      claim_q <= 1'b0;
    else if (claim_evt)
      claim_q <= 1'b1;
    else if (frame_n_i && irdy_n_i)
      claim_q <= 1'b0;
  end

  assign devsel_n_o = 1'b0;
  assign devsel_n_oe_o = claim_q;

  // ----------------------------------------------------------------------------
  // Parity checking
  // ----------------------------------------------------------------------------
  logic [31:0] ad_q;
  logic [3:0] cbe_n_q;
  logic chk_addr_q;
  logic chk_data_q;
  logic chk_special_q;
  logic chk_wr_q;
  logic par_err;
  logic addr_perr;
  logic spc_perr;
  logic dat_perr;

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
    begin
      ad_q <= 32'h0000_0000;
      cbe_n_q <= 4'h0;
      chk_addr_q <= 1'b0;
      chk_data_q <= 1'b0;
      chk_special_q <= 1'b0;
      chk_wr_q <= 1'b0;
    end
    else
    begin
      ad_q <= ad_i;
      cbe_n_q <= cbe_n_i;
      chk_addr_q <= addr_ph;
      chk_data_q <= !addr_ph && !irdy_n_i && !trdy_n_i;
      chk_special_q <= (cmd_q == `PCIARB_CMD_SPECIAL);
      chk_wr_q <= claim_q && (cmd_q == `PCIARB_CMD_CFG_WR);
    end
  end

  // Parity lags its address or data by one clock
  assign par_err = parity_bad(ad_q, cbe_n_q, par_i);
  assign addr_perr = chk_addr_q && par_err;
  assign spc_perr = chk_data_q && chk_special_q && par_err;
  assign dat_perr = chk_data_q && !chk_special_q && chk_wr_q && par_err;

  // ----------------------------------------------------------------------------
  // Error pins
  // ----------------------------------------------------------------------------
  logic fatal_q;
  logic perr_oe_q;
  logic serr_oe_q;
  logic serr_n_q;
  logic serr_seen_p;

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      fatal_q <= 1'b0;
    else
      fatal_q <= core_s[2];
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      perr_oe_q <= 1'b0;
    else
      perr_oe_q <= dat_perr;
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      serr_oe_q <= 1'b0;
    else
      serr_oe_q <= !host_q && (addr_perr || spc_perr || (core_s[2] && !fatal_q));
  end

  always_ff @(posedge pci_clk_i)
  begin
    if (pci_rst)
      serr_n_q <= 1'b1;
    else
      serr_n_q <= serr_n_i;
  end

  // Host mode only watches the line
  assign serr_seen_p = host_q && serr_n_q && !serr_n_i;

  assign perr_n_o = 1'b0;
  assign perr_n_oe_o = perr_oe_q;
  assign serr_n_o = 1'b0;
  assign serr_n_oe_o = serr_oe_q;

  // ----------------------------------------------------------------------------
  // Status back to the core domain
  // ----------------------------------------------------------------------------
  logic [2:0] stat_s;
  logic ref_rst_q;

  always_ff @(posedge ref_clk_i)
  begin
    ref_rst_q <= rst_i;
  end

  pciarb_sync #(.W(3)) u_stat_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({own_gnt_p_q, host_q, arb_int_q}),
    .q_o(stat_s)
  );

  assign arb_internal_o = stat_s[0];
  assign host_mode_o = stat_s[1];
  assign own_gnt_o = stat_s[2];

  pciarb_evt_if claim_if ();
  pciarb_evt_if serr_if ();

  assign claim_if.src_pulse = claim_evt;
  assign serr_if.src_pulse = serr_seen_p;

  pciarb_evt_xfer u_claim_xfer (
    .src_clk_i(pci_clk_i),
    .src_rst_i(pci_rst),
    .dst_clk_i(ref_clk_i),
    .dst_rst_i(rst_i || ref_rst_q),
    .evt(claim_if.xfer)
  );

  pciarb_evt_xfer u_serr_xfer (
    .src_clk_i(pci_clk_i),
    .src_rst_i(pci_rst),
    .dst_clk_i(ref_clk_i),
    .dst_rst_i(rst_i || ref_rst_q),
    .evt(serr_if.xfer)
  );

  assign cfg_claim_o = claim_if.dst_pulse;
  assign serr_seen_o = serr_if.dst_pulse;

endmodule : pciarb_top

/* File: verification/pciarb_checker.sv */
// Assertion checker for the arbitration and error pin block
`timescale 1ns/1ps
module pciarb_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic pci_clk_i,
  input wire logic ext_int_req_i,
  input wire logic fatal_err_i,
  input wire logic [3:0] req_n_i,
  input wire logic req0_n_oe_o,
  input wire logic ext_int_o,
  input wire logic ext_int_oe_o,
  input wire logic [3:0] gnt_n_o,
  input wire logic [3:0] gnt_n_oe_o,
  input wire logic frame_n_i,
  input wire logic idsel_i,
  input wire logic [3:0] cbe_n_i,
  input wire logic devsel_n_oe_o,
  input wire logic perr_n_o,
  input wire logic perr_n_oe_o,
  input wire logic serr_n_o,
  input wire logic serr_n_oe_o,
  input wire logic arb_internal_o,
  input wire logic host_mode_o,
  input wire logic cfg_claim_o
);
  // --------------------------------------------------------------
  // Settle counter after reset release
  // --------------------------------------------------------------
  logic [6:0] settle_q;
  logic ok;
  always_ff @(posedge ref_clk_i)
    if (rst_i)
      settle_q <= 7'h00;
    else if (!settle_q[6])
      settle_q <= settle_q + 7'h01;
  assign ok = settle_q[6];

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_one_grant: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    $onehot0(~gnt_n_o)) else $error("more than one grant");
  a_grant_to_req: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    ok && arb_internal_o |-> ((~gnt_n_o) & $past(req_n_i, 1) & $past(req_n_i, 2)) == 4'h0)
    else $error("grant without request");
  a_grant_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ok |-> gnt_n_oe_o == {4{arb_internal_o}}) else $error("grant direction wrong");
  a_req_dir: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ok |-> (req0_n_oe_o == !arb_internal_o) && !(arb_internal_o && ext_int_oe_o))
    else $error("request pin direction wrong");
  a_open_drain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(ext_int_oe_o && ext_int_o) && !(serr_n_oe_o && serr_n_o) && !(perr_n_oe_o && perr_n_o))
    else $error("open-drain pin driven high");
  a_host_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ok && host_mode_o |-> !serr_n_oe_o) else $error("system error driven in host mode");
  a_int_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ok && !arb_internal_o && $rose(ext_int_req_i) |-> ##[1:40] ext_int_oe_o)
    else $error("interrupt output late");
  a_cfg_claim: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    ok && $fell(frame_n_i) && idsel_i && cbe_n_i[3:1] == 3'h5 |=> devsel_n_oe_o)
    else $error("config access not claimed");
  a_no_claim: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    ok && $fell(frame_n_i) && !idsel_i && !devsel_n_oe_o |=> !devsel_n_oe_o)
    else $error("claim without select");
  a_claim_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ok && $rose(devsel_n_oe_o) |-> ##[1:12] cfg_claim_o) else $error("claim pulse missing");
  a_perr_pulse: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    perr_n_oe_o |=> !perr_n_oe_o) else $error("parity error pulse too long");
  a_fatal_serr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ok && !host_mode_o && $rose(fatal_err_i) |-> ##[1:40] serr_n_oe_o)
    else $error("fatal error not reported");
  c_grant3: cover property (@(posedge pci_clk_i) !gnt_n_o[3]);
  c_claim: cover property (@(posedge pci_clk_i) $rose(devsel_n_oe_o));
  c_serr: cover property (@(posedge pci_clk_i) serr_n_oe_o);
endmodule : pciarb_checker

bind pciarb_top pciarb_checker u_pciarb_checker (.*);

/* File: verification/pciarb_bus_model.sv */
// Partner model: bus masters with pull-ups and an external arbiter
`timescale 1ns/1ps
module pciarb_bus_model (
  input wire logic pci_clk_i,
  input wire logic ext_mode_i,
  input wire logic [3:0] want_i,
  input wire logic [3:0] gnt_pin_i,
  input wire logic req0_pin_i,
  output logic [3:0] req_n_o,
  output logic [3:0] gnt_n_o
);
  logic [1:0] held_q [4];
  // Masters hold the bus three cycles then let go
  always_ff @(posedge pci_clk_i)
    for (int i = 0; i < 4; i++)
      held_q[i] <= (!gnt_pin_i[i] && !ext_mode_i) ? held_q[i] + 2'h1 : 2'h0;
  always_comb
    for (int i = 0; i < 4; i++)
      req_n_o[i] = ext_mode_i || !want_i[i] || held_q[i] == 2'h3;
  // External arbiter grants line 0, lines 3..1 pulled up
  always_ff @(posedge pci_clk_i)
    gnt_n_o <= {3'h7, !(ext_mode_i && !req0_pin_i)};
endmodule : pciarb_bus_model

/* File: verification/tb_top.sv */
// Testbench for the arbitration and error pin block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, pci_clk, rst, arb_strap, host_strap, own_req, ext_int_req, fatal_err;
  logic frame_n, irdy_n, trdy_n, idsel, par, tb_serr_n, serr_line;
  logic [31:0] ad;
  logic [3:0] cbe_n, want, req_n, gnt_n, m_req_n, m_gnt_n, gnt_o, gnt_oe;
  logic req0_o, req0_oe, int_o, int_oe, dev_o, dev_oe, perr_o, perr_oe, serr_o, serr_oe;
  logic arb_int, host, own_gnt, claim, serr_seen;
  logic [3:0] cmds [4] = '{4'h1, 4'hA, 4'hB, 4'h6};
  integer seed = 65, failures = 0, checked = 0;
  integer n_serr = 0, n_perr = 0, n_seen = 0, n_claim = 0, seen0 = 0;

  // --------------------------------------------------------------
  // Clocks, wires and instances
  // --------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    pci_clk = 1'b0;
    #7;
    forever #15 pci_clk = ~pci_clk;
  end
  assign req_n = {m_req_n[3:2], int_oe ? int_o : m_req_n[1], req0_oe ? req0_o : m_req_n[0]};
  assign gnt_n = (gnt_oe & gnt_o) | (~gnt_oe & m_gnt_n);
  assign serr_line = serr_oe ? serr_o : tb_serr_n;
  always @(posedge pci_clk) if (serr_oe === 1'b1) n_serr <= n_serr + 1;
  always @(posedge pci_clk) if (perr_oe === 1'b1) n_perr <= n_perr + 1;
  always @(posedge ref_clk) if (serr_seen === 1'b1) n_seen <= n_seen + 1;
  always @(posedge ref_clk) if (claim === 1'b1) n_claim <= n_claim + 1;

  pciarb_top u_pciarb_top (.ref_clk_i(ref_clk), .rst_i(rst), .pci_clk_i(pci_clk),
    .arb_strap_i(arb_strap), .host_strap_i(host_strap), .own_req_i(own_req),
    .ext_int_req_i(ext_int_req), .fatal_err_i(fatal_err), .req_n_i(req_n),
    .req0_n_o(req0_o), .req0_n_oe_o(req0_oe), .ext_int_o(int_o), .ext_int_oe_o(int_oe),
    .gnt_n_i(gnt_n), .gnt_n_o(gnt_o), .gnt_n_oe_o(gnt_oe), .frame_n_i(frame_n),
    .irdy_n_i(irdy_n), .trdy_n_i(trdy_n), .idsel_i(idsel), .ad_i(ad), .cbe_n_i(cbe_n),
    .par_i(par), .devsel_n_i(dev_oe ? dev_o : 1'b1), .devsel_n_o(dev_o),
    .devsel_n_oe_o(dev_oe), .perr_n_i(perr_oe ? perr_o : 1'b1), .perr_n_o(perr_o),
    .perr_n_oe_o(perr_oe), .serr_n_i(serr_line), .serr_n_o(serr_o), .serr_n_oe_o(serr_oe),
    .arb_internal_o(arb_int), .host_mode_o(host), .own_gnt_o(own_gnt),
    .cfg_claim_o(claim), .serr_seen_o(serr_seen));
  pciarb_bus_model u_pciarb_bus_model (.pci_clk_i(pci_clk), .ext_mode_i(!arb_strap),
    .want_i(want), .gnt_pin_i(gnt_n), .req0_pin_i(req_n[0]), .req_n_o(m_req_n),
    .gnt_n_o(m_gnt_n));

  // --------------------------------------------------------------
  // Tasks and expectations
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  function automatic logic [1:0] exp_serr(input logic h, input logic [3:0] c, input logic ba,
                                          input logic bd);
    return h ? 2'h0 : {1'b0, ba} + {1'b0, bd && c == 4'h1};
  endfunction : exp_serr
  function automatic logic exp_perr(input logic [3:0] c, input logic s, input logic bd);
    return bd && s && c == 4'hB;
  endfunction : exp_perr
  task automatic do_reset(input logic a, input logic h);
    @(negedge ref_clk);
    rst = 1'b1;
    arb_strap = a;
    host_strap = h;
    repeat (30) @(negedge ref_clk);
    rst = 1'b0;
    repeat (80) @(negedge ref_clk);
    chk(arb_int, a, "arbiter mode");
    chk(host, h, "host mode");
    chk(gnt_oe, {4{a}}, "grant direction");
    chk(req0_oe, !a, "request 0 direction");
    chk(int_oe, 1'b0, "interrupt idle");
  endtask : do_reset
  task automatic bus_cycle(input logic [3:0] cmd, input logic s, input logic ba, input logic bd);
    @(negedge pci_clk);
    frame_n = 1'b0;
    ad = 32'($random(seed));
    cbe_n = cmd;
    idsel = s;
    @(negedge pci_clk);
    chk({dev_oe, dev_o}, {s && cmd[3:1] == 3'h5, 1'b0}, "device select drive");
    par = ^{ad, cbe_n} ^ ba;
    {frame_n, irdy_n, trdy_n, idsel} = 4'h8;
    ad = 32'($random(seed));
    cbe_n = 4'h0;
    @(negedge pci_clk);
    par = ^{ad, cbe_n} ^ bd;
    {irdy_n, trdy_n} = 2'h3;
    ad = ~ad;
    repeat (6) @(negedge pci_clk);
  endtask : bus_cycle
  task automatic run_bus(input logic h);
    logic [3:0] cmd;
    logic s, ba, bd;
    integer s0, p0, c0;
    for (int k = 0; k < 12; k++)
    begin
      cmd = cmds[k % 4];
      {s, ba, bd} = 3'($random(seed));
      if (k < 4)
        {s, ba, bd} = 3'h5;
      if (ba)
        s = 1'b0;
      s0 = n_serr;
      p0 = n_perr;
      c0 = n_claim;
      bus_cycle(cmd, s, ba, bd);
      chk(n_serr - s0, exp_serr(h, cmd, ba, bd), "system error count");
      chk(n_perr - p0, exp_perr(cmd, s, bd), "data parity count");
      chk(n_claim - c0, s && cmd[3:1] == 3'h5, "config claim count");
    end
  endtask : run_bus

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial
  begin
    {rst, arb_strap, host_strap, tb_serr_n, par, frame_n, irdy_n, trdy_n} = 8'hFF;
    {own_req, ext_int_req, fatal_err, idsel, want} = 8'h00;
    ad = 32'h0;
    cbe_n = 4'hF;
    do_reset(1'b1, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      want = 4'h1 << i;
      for (int k = 0; k < 40 && gnt_n[i] !== 1'b0; k++) @(negedge pci_clk);
      chk(gnt_n[i], 1'b0, "master not granted");
      want = 4'h0;
      repeat (6) @(negedge pci_clk);
    end
    repeat (80)
    begin
      @(negedge pci_clk);
      want = 4'($random(seed));
      @(negedge ref_clk);
      own_req = 1'($random(seed));
    end
    {want, own_req} = 5'h00;
    seen0 = n_seen;
    @(negedge pci_clk);
    tb_serr_n = 1'b0;
    repeat (2) @(negedge pci_clk);
    tb_serr_n = 1'b1;
    repeat (4) @(negedge pci_clk);
    chk(n_seen - seen0, 1, "host error sample");
    run_bus(1'b1);
    $display("test internal_host done");
    do_reset(1'b0, 1'b0);
    want = 4'hF;
    own_req = 1'b1;
    for (int k = 0; k < 200 && own_gnt !== 1'b1; k++) @(negedge ref_clk);
    chk(own_gnt, 1'b1, "external grant");
    chk(req0_o, 1'b0, "own request out");
    chk(gnt_oe, 4'h0, "grants stay inputs");
    own_req = 1'b0;
    ext_int_req = 1'b1;
    repeat (6) @(negedge pci_clk);
    chk({int_oe, int_o}, 2'h2, "interrupt out");
    ext_int_req = 1'b0;
    repeat (6) @(negedge pci_clk);
    chk(int_oe, 1'b0, "interrupt released");
    s_fatal();
    run_bus(1'b0);
    $display("test external_satellite done");
    report_and_stop;
  end
  task automatic s_fatal;
    integer s0;
    s0 = n_serr;
    @(negedge ref_clk);
    fatal_err = 1'b1;
    repeat (8) @(negedge pci_clk);
    chk(n_serr - s0, 1, "fatal error report");
    fatal_err = 1'b0;
  endtask : s_fatal
endmodule : tb_top
